// ===== hdr_regs_pkg.sv
package hdr_regs_pkg;

    // Bus geometry: one register per aligned 32-bit word, byte address = 4 * index.
    localparam int DAT_W = 32;
    localparam int ADR_W = 10;
    localparam int SEL_W = 4;
    localparam int BYTE_W = 8;
    localparam int IDX_LSB = 2;
    localparam int LEN_W = 16;

    // Register indices.
    localparam logic [7:0] IDX_SERIAL_TOP = 8'h1F;
    localparam logic [7:0] IDX_PAGE_SELECT = 8'h20;
    localparam logic [7:0] IDX_TXN_COUNT = 8'h21;
    localparam logic [7:0] IDX_LEN_LOW = 8'h22;
    localparam logic [7:0] IDX_LEN_HIGH = 8'h23;
    localparam logic [7:0] IDX_PAGED_FIRST = 8'h24;
    localparam logic [7:0] IDX_RESULT_SEQ = 8'h24;
    localparam logic [7:0] IDX_DIE_TEMP = 8'h25;
    localparam logic [7:0] IDX_VALID_ZONES = 8'h26;
    localparam logic [7:0] IDX_PAGED_LAST = 8'hDF;
    localparam logic [7:0] IDX_PAGE_COMMAND = 8'hF0;
    localparam int PAGED_DEPTH = 188;
    localparam int PAGED_AW = 8;

    // Serial value slice shown at the top serial byte.
    localparam int SERIAL_W = 32;
    localparam int SERIAL_TOP_MSB = 31;
    localparam int SERIAL_TOP_LSB = 24;

    // Page selector codes.
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] PAGE_RESULT = 8'h10;
    localparam logic [7:0] PAGE_COMMON = 8'h16;
    localparam logic [7:0] PAGE_DETECTOR_ONE = 8'h17;
    localparam logic [7:0] PAGE_DETECTOR_TWO = 8'h18;
    localparam logic [7:0] PAGE_FACTORY_CAL = 8'h19;
    localparam logic [7:0] PAGE_RAW_HISTOGRAM = 8'h81;

    // Application that owns the measurement result record.
    localparam logic [7:0] APP_MAIN = 8'h03;

    // Reset values and field layout of the result sequence byte.
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] LEN_RESET = 16'h0000;
    localparam int SUB_CAPTURE_W = 2;
    localparam logic [5:0] SEQ_STEP_EXT = 6'h01;
    localparam logic [7:0] SEQ_STEP = 8'h01;
    localparam logic [7:0] TXN_STEP = 8'h01;

    // Per-zone report codes from the measurement engine.
    typedef enum logic [1:0] {
        ZONE_INVALID = 2'h0,
        ZONE_ONE_TARGET = 2'h1,
        ZONE_TWO_TARGETS = 2'h2,
        ZONE_NO_TARGET = 2'h3
    } zone_status_t;

    // Bus slave sequencing.
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_FETCH = 3'b010,
        BUS_DONE = 3'b100
    } bus_state_t;

endpackage

// ===== reg_access_if.sv
`timescale 1ns/1ns
interface reg_access_if import hdr_regs_pkg::*; ();
    logic req;
    logic we;
    logic sel_low;
    logic [BYTE_W-1:0] index;
    logic [BYTE_W-1:0] wdata;
    logic [BYTE_W-1:0] rdata;

    modport bus (output req, output we, output sel_low, output index, output wdata, input rdata);
    modport core (input req, input we, input sel_low, input index, input wdata, output rdata);
endinterface

// ===== paged_byte_ram.sv
`timescale 1ns/1ns
module paged_byte_ram import hdr_regs_pkg::*; #(
    parameter int DEPTH = PAGED_DEPTH,
    parameter int AW = PAGED_AW,
    parameter int W = BYTE_W
) (
    input wire logic mclk_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [W-1:0] wr_data_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [W-1:0] rd_data_o
);

    logic [W-1:0] mem [DEPTH];

    // Contents carry no reset; the firmware refills a page after every switch.
    always_ff @(posedge mclk_i) begin
        if (wr_en_i && (int'(wr_addr_i) < DEPTH)) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    // Registered read: data is valid one cycle after the address.
    always_ff @(posedge mclk_i) begin
        if (int'(rd_addr_i) < DEPTH) begin
            rd_data_o <= mem[rd_addr_i];
        end else begin
            rd_data_o <= '0;
        end
    end

endmodule

// ===== wb_byte_slave.sv
`timescale 1ns/1ns
module wb_byte_slave import hdr_regs_pkg::*; (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [SEL_W-1:0] wb_sel_i,
    input wire logic [DAT_W-1:0] wb_dat_i,
    output logic [DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    reg_access_if.bus acc
);

    bus_state_t state_ff;
    bus_state_t nxt_state;

    // The core sees one request pulse per bus cycle, taken only from idle.
    assign acc.req = (state_ff == BUS_IDLE) && wb_cyc_i && wb_stb_i;
    assign acc.we = wb_we_i;
    assign acc.sel_low = wb_sel_i[0];
    assign acc.index = wb_adr_i[ADR_W-1:IDX_LSB];
    assign acc.wdata = wb_dat_i[BYTE_W-1:0];

    // Fetch waits one cycle for the registered page memory before acking.
    always_comb begin
        case (state_ff)
            BUS_IDLE: nxt_state = acc.req ? BUS_FETCH : BUS_IDLE;
            BUS_FETCH: nxt_state = BUS_DONE;
            BUS_DONE: nxt_state = BUS_IDLE;
            default: nxt_state = BUS_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= BUS_IDLE;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            state_ff <= nxt_state;
            wb_ack_o <= (state_ff == BUS_FETCH);
            if (state_ff == BUS_FETCH) begin
                wb_dat_o <= {{(DAT_W-BYTE_W){1'b0}}, acc.rdata}; // Upper lanes read as zero.
            end
        end
    end

endmodule

// ===== result_page_header_registers.sv
`timescale 1ns/1ns
// Operation
// - The top serial byte at 0x1F shows serial bits 31:24, read-only, with no reset value.
// - The page selector at 0x20 chooses what the range 0x24 to 0xDF shows and resets to zero.
// - Selector 0x10 shows the measurement result record and 0x16 the common configuration page.
// - Selector 0x17 shows detector configuration page one and 0x18 page two.
// - Selector 0x19 shows the factory calibration page and 0x81 the raw histogram page.
// - The transaction counter at 0x21 is read-only, resets to zero and changes on every transaction.
// - The payload length is 16 bits read-only, low byte at 0x22, high byte at 0x23, reset to zero.
// - The result fields from 0x24 are valid only with application 0x03 and selector 0x10.
// - The result sequence byte at 0x24 is read-only, resets to zero and advances per record.
// - In extended zone mode bits 1:0 carry the sub-capture index and bits 7:2 the running count.
// - The die temperature at 0x25 is a signed whole-degree byte, read-only, reset to zero.
// - The valid-zone count at 0x26 counts zones with one, two or no target, read-only, reset to zero.
// - A zone that reports no target is counted as valid.
module result_page_header_registers import hdr_regs_pkg::*; #(
    parameter int NUM_ZONES = 64
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [SEL_W-1:0] wb_sel_i,
    input wire logic [DAT_W-1:0] wb_dat_i,
    output logic [DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [SERIAL_W-1:0] serial_i,
    input wire logic [BYTE_W-1:0] app_id_i,
    input wire logic [LEN_W-1:0] payload_len_i,
    input wire logic result_strobe_i,
    input wire logic extended_mode_i,
    input wire logic [SUB_CAPTURE_W-1:0] sub_capture_i,
    input wire logic [BYTE_W-1:0] temperature_i,
    input wire logic [2*NUM_ZONES-1:0] zone_status_i,
    input wire logic page_wr_i,
    input wire logic [PAGED_AW-1:0] page_waddr_i,
    input wire logic [BYTE_W-1:0] page_wdata_i,
    output logic [BYTE_W-1:0] page_select_o,
    output logic page_changed_o
);

    // The tally must also hold the case where every zone is valid, hence the
    // extra value in the width calculation.
    localparam int CNT_W = $clog2(NUM_ZONES + 1);

    // One byte access per bus cycle travels from the bus slave to the core.
    reg_access_if acc ();

    // Registered header state and the captured result record.
    logic [BYTE_W-1:0] page_ff;
    logic [BYTE_W-1:0] txn_ff;
    logic [LEN_W-1:0] len_ff;
    logic [BYTE_W-1:0] seq_ff;
    logic [BYTE_W-1:0] temp_ff;
    logic [BYTE_W-1:0] zones_ff;
    logic page_changed_ff;

    // Next values and helpers of the result capture.
    logic [BYTE_W-1:0] nxt_seq;
    logic [BYTE_W-1:0] nxt_zones;
    logic [CNT_W-1:0] zone_sum;
    logic [NUM_ZONES-1:0] zone_valid;
    logic [BYTE_W-1:0] ram_rdata;

    // Decode and read-path nets.
    wire logic host_write;
    wire logic cmd_write;
    wire logic page_known;
    wire logic page_switch;
    wire logic txn_event;
    wire logic results_visible;
    wire logic in_paged;
    wire logic in_result_fields;

    // Command code and register select lines.
    wire logic cmd_result;
    wire logic cmd_common;
    wire logic cmd_detector_one;
    wire logic cmd_detector_two;
    wire logic cmd_factory_cal;
    wire logic cmd_raw_histogram;
    wire logic hit_serial;
    wire logic hit_page;
    wire logic hit_txn;
    wire logic hit_len_low;
    wire logic hit_len_high;
    wire logic hit_seq;
    wire logic hit_temp;
    wire logic [PAGED_AW-1:0] ram_raddr;
    wire logic [BYTE_W-1:0] header_rdata;
    wire logic [BYTE_W-1:0] paged_rdata;
    wire logic [BYTE_W-1:0] result_rdata;
    wire logic [SERIAL_TOP_LSB:0] unused_serial;

    // Bus slave: takes the Wishbone cycle and hands one byte access to the core.
    // Writes act at the edge that takes the request; reads are captured one
    // cycle later so that the registered page memory has settled.
    // The ack therefore comes at a fixed distance from the request.
    wb_byte_slave u_bus (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .acc(acc.bus)
    );

    // Paged content other than the live result fields lives in a small memory
    // that the firmware rewrites whenever the selector moves.
    // The memory has no reset; a page never filled reads whatever the cells
    // held, so software should wait for fresh content first.
    // Writes beyond the memory depth are dropped.
    paged_byte_ram #(
        .DEPTH(PAGED_DEPTH),
        .AW(PAGED_AW),
        .W(BYTE_W)
    ) u_page_ram (
        .mclk_i(mclk_i),
        .wr_en_i(page_wr_i),
        .wr_addr_i(page_waddr_i),
        .wr_data_i(page_wdata_i),
        .rd_addr_i(ram_raddr),
        .rd_data_o(ram_rdata)
    );

    // Only the command register accepts a write; every other index ignores it.
    // The command lives in the low byte lane, so a write that does not
    // enable that lane is taken as no command at all.
    // Read-only writes dropped.
    assign host_write = acc.req && acc.we && acc.sel_low;
    assign cmd_write = host_write && (acc.index == IDX_PAGE_COMMAND);

    // The selector is steered only through the command register, never by a
    // write to its own address, and unknown page codes leave it untouched.
    // Command-driven page change.
    assign cmd_result = (acc.wdata == PAGE_RESULT);
    assign cmd_common = (acc.wdata == PAGE_COMMON);
    assign cmd_detector_one = (acc.wdata == PAGE_DETECTOR_ONE);
    assign cmd_detector_two = (acc.wdata == PAGE_DETECTOR_TWO);
    assign cmd_factory_cal = (acc.wdata == PAGE_FACTORY_CAL);
    assign cmd_raw_histogram = (acc.wdata == PAGE_RAW_HISTOGRAM);

    // An unknown code is dropped rather than stored, so the selector only
    // ever names a page that the firmware knows how to fill.
    assign page_known = cmd_result
                     || cmd_common
                     || cmd_detector_one
                     || cmd_detector_two
                     || cmd_factory_cal
                     || cmd_raw_histogram;

    // A command is applied only when it carries a known code.
    assign page_switch = cmd_write && page_known;

    // A page switch and a newly published result record both count as transactions.
    // When both fall in one cycle they are a single transaction: the counter
    // moves once and the length of the new content is the one captured.
    assign txn_event = page_switch || result_strobe_i;

    // The record fields mean something only for the main application on the
    // result page; anywhere else the page memory shows through.
    // Result field gating.
    assign results_visible = (app_id_i == APP_MAIN) && (page_ff == PAGE_RESULT);

    // Address decode of the paged window and of the live result fields within it.
    // Indices below the window wrap to large memory addresses; the memory
    // answers zero beyond its depth and the mux never picks them anyway.
    assign in_paged = (acc.index >= IDX_PAGED_FIRST) && (acc.index <= IDX_PAGED_LAST);
    assign in_result_fields = results_visible && (acc.index >= IDX_RESULT_SEQ) && (acc.index <= IDX_VALID_ZONES);
    assign ram_raddr = PAGED_AW'(acc.index - IDX_PAGED_FIRST);

    // One select line per register keeps the read muxes flat and easy to
    // hold against the register map.
    assign hit_serial = (acc.index == IDX_SERIAL_TOP);
    assign hit_page = (acc.index == IDX_PAGE_SELECT);
    assign hit_txn = (acc.index == IDX_TXN_COUNT);
    assign hit_len_low = (acc.index == IDX_LEN_LOW);
    assign hit_len_high = (acc.index == IDX_LEN_HIGH);
    assign hit_seq = (acc.index == IDX_RESULT_SEQ);
    assign hit_temp = (acc.index == IDX_DIE_TEMP);

    // Header registers below the paged window; unmapped indices, the
    // write-only command register among them, read as zero.
    // The serial byte passes straight through with no register, so it has
    // no reset value of its own and follows the serial input at all times.
    // Top serial byte.
    assign header_rdata = hit_serial ? serial_i[SERIAL_TOP_MSB:SERIAL_TOP_LSB]
                        : hit_page ? page_ff
                        : hit_txn ? txn_ff
                        : hit_len_low ? len_ff[BYTE_W-1:0]
                        : hit_len_high ? len_ff[LEN_W-1:BYTE_W]
                        : BYTE_RESET;

    // Live result fields, shown over the memory only while the record is mapped.
    assign result_rdata = hit_seq ? seq_ff
                        : hit_temp ? temp_ff
                        : zones_ff;
    // Every page other than the live record is served from the memory; the
    // selector only decides whether the record fields cover its first bytes.
    // Paged content selection.
    assign paged_rdata = in_result_fields ? result_rdata : ram_rdata;
    assign acc.rdata = in_paged ? paged_rdata : header_rdata;

    // The lower serial bytes belong to other registers and are not shown here.
    // The sink marks them, and the pulse that only feeds an output, as unused.
    assign unused_serial = {serial_i[SERIAL_TOP_LSB-1:0], page_changed_ff};

    // Each zone is judged on its own report code. Only the invalid code is
    // left out; a zone that saw no target still finished its measurement.
    // No-target counts valid.
    generate
        for (genvar z = 0; z < NUM_ZONES; z++) begin : g_zone
            wire logic [1:0] code = zone_status_i[2*z +: 2];
            assign zone_valid[z] = (code == ZONE_ONE_TARGET)
                                || (code == ZONE_TWO_TARGETS)
                                || (code == ZONE_NO_TARGET);
        end
    endgenerate

    // Population count of the valid zones; the count saturates nowhere and only
    // its low byte is kept, which holds the default of 64 zones; nothing limits the parameter.
    // The sum is formed every cycle but captured only on a result strobe.
    // Valid-zone tally.
    always_comb begin
        zone_sum = '0;
        for (int i = 0; i < NUM_ZONES; i++) begin
            zone_sum = zone_sum + CNT_W'(zone_valid[i]);
        end
    end
    assign nxt_zones = BYTE_W'(zone_sum);

    // In extended mode the low bits hold the sub-capture, so the running count
    // wraps every 64 records instead of every 256.
    // The sub-capture index is taken from the engine with each record; the
    // count in the upper bits steps by one per record whatever the index.
    // Sequence byte update.
    assign nxt_seq = extended_mode_i
                   ? {seq_ff[BYTE_W-1:SUB_CAPTURE_W] + SEQ_STEP_EXT, sub_capture_i}
                   : seq_ff + SEQ_STEP;

    // Page selector and change notice to the firmware, which must refill the memory.
    // Both move at the edge that takes the command, one edge before the bus
    // ack, so a read that follows the ack already sees the new page.
    // Selector reset and update.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            page_ff <= PAGE_RESET;
            page_changed_ff <= 1'b0;
        end else begin
            page_changed_ff <= page_switch;
            if (page_switch) begin
                page_ff <= acc.wdata;
            end
        end
    end

    // Transaction identifier and the payload length that goes with it.
    // The two length bytes are separate reads with no latch between them; a
    // transaction between them gives a torn value, so software should read
    // the counter before and after the pair and retry if it moved.
    // Transaction and length.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            txn_ff <= BYTE_RESET;
            len_ff <= LEN_RESET;
        end else if (txn_event) begin
            txn_ff <= txn_ff + TXN_STEP;
            len_ff <= payload_len_i;
        end
    end

    // Result record fields are captured together so a reader never sees a mix
    // of two records within one published set.
    // The temperature is kept as raw two's complement bits; nothing here
    // converts or clamps it, so the whole signed byte range passes through.
    // Signed temperature capture.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            seq_ff <= BYTE_RESET;
            temp_ff <= BYTE_RESET;
            zones_ff <= BYTE_RESET;
        end else if (result_strobe_i) begin
            seq_ff <= nxt_seq;
            temp_ff <= temperature_i;
            zones_ff <= nxt_zones;
        end
    end

    // Status outputs come straight from their registers.
    // The change pulse lets the firmware start refilling the page memory
    // without polling the selector.
    assign page_select_o = page_ff;
    assign page_changed_o = page_changed_ff;

endmodule

// ===== hdr_regs_asserts.sv
`timescale 1ns/1ns
module hdr_regs_asserts import hdr_regs_pkg::*; (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [SERIAL_W-1:0] serial_i,
    input wire logic [BYTE_W-1:0] page_select_o,
    input wire logic page_changed_o
);
    // The master holds the address through the ack cycle, so it still names the register read.
    wire rd_ack = wb_ack_o & ~wb_we_i;
    wire [7:0] idx = wb_adr_i[9:2];
    wire cmd_wr = wb_cyc_i & wb_stb_i & wb_we_i & (idx == IDX_PAGE_COMMAND);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stood longer than one cycle");
    a_ack_latency: assert property ($rose(wb_cyc_i & wb_stb_i) |-> !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o)
        else $error("ack not two cycles after request");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i & wb_stb_i, 2))
        else $error("ack without request");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_serial_top: assert property (rd_ack && idx == IDX_SERIAL_TOP |-> wb_dat_o[7:0] == serial_i[31:24])
        else $error("serial top byte wrong");
    a_unmapped_zero: assert property (rd_ack && idx == 8'h00 |-> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_page_read: assert property (rd_ack && idx == IDX_PAGE_SELECT |-> wb_dat_o[7:0] == page_select_o)
        else $error("selector read differs from selector");
    a_page_cause: assert property (!$stable(page_select_o) |-> $past(cmd_wr))
        else $error("selector changed without command");
    a_page_legal: assert property (page_select_o inside {8'h00, 8'h10, 8'h16, 8'h17, 8'h18, 8'h19, 8'h81})
        else $error("selector holds unknown page");
    a_changed_pulse: assert property (!$stable(page_select_o) |-> page_changed_o)
        else $error("no page change pulse");
    a_changed_single: assert property (page_changed_o |=> !page_changed_o)
        else $error("page change pulse longer than one cycle");
endmodule

bind result_page_header_registers hdr_regs_asserts u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .serial_i(serial_i), .page_select_o(page_select_o), .page_changed_o(page_changed_o));

// ===== host_model.sv
`timescale 1ns/1ns
module host_model (
    input wire logic mclk_i,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [9:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_i
);
    // Byte enables of the next access; a scenario clears bit 0 to test lane checks.
    logic [3:0] sel_mask = 4'h1;

    // Idle bus at time zero.
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 10'h000;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h00000000;
    end

    // one bus access
    // One classic cycle; the wait is bounded so a silent slave cannot hang the run.
    task automatic access(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                          output logic [31:0] rd, output bit to);
        to = 1'b1;
        @(posedge mclk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= {idx, 2'b00};
        wb_sel_o <= sel_mask;
        wb_dat_o <= {24'h000000, wd};
        for (int n = 0; n < 20 && to; n++) begin
            @(posedge mclk_i);
            if (wb_ack_i === 1'b1) begin
                to = 1'b0;
            end
        end
        rd = wb_dat_i;
        // Released lines show garbage, not the last value.
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_adr_o <= ~wb_adr_o;
        wb_dat_o <= ~wb_dat_o;
    endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ns
module tb;
    logic mclk_i = 1'b0, rst_i = 1'b1, strobe = 1'b0, ext = 1'b0, page_wr = 1'b0;
    logic [31:0] serial = 32'hA5C31E77;
    logic [7:0] app = 8'h03, temp = 8'h00, waddr = 8'h00, wdata = 8'h00;
    logic [15:0] plen = 16'h0000;
    logic [1:0] sub = 2'h0;
    logic [127:0] zones = '0;
    wire cyc, stb, we, ack;
    wire [9:0] adr;
    wire [3:0] sel;
    wire [31:0] wdat, rdat;
    int n_mismatch = 0, check_count = 0;
    logic [7:0] codes [6] = '{8'h10, 8'h16, 8'h17, 8'h18, 8'h19, 8'h81};

    // Clock at 250 MHz.
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end

    host_model host (.mclk_i(mclk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
        .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack));
    result_page_header_registers DUT (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .serial_i(serial), .app_id_i(app), .payload_len_i(plen), .result_strobe_i(strobe),
        .extended_mode_i(ext), .sub_capture_i(sub), .temperature_i(temp), .zone_status_i(zones),
        .page_wr_i(page_wr), .page_waddr_i(waddr), .page_wdata_i(wdata), .page_select_o(), .page_changed_o());

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
        bit to;
        host.access(w, idx, wd, rd, to);
        if (to) begin
            $display("wrong value ack expected 1 seen 0");
            n_mismatch++;
            print_verdict();
        end
    endtask

    task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 8'h00, d);
        check_count++;
        if (d !== {24'h000000, exp}) begin
            $display("wrong value %s expected %h seen %h", nm, exp, d);
            n_mismatch++;
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, d);
    endtask

    // Publishes one result record from the measurement engine.
    task automatic pulse_result();
        @(posedge mclk_i);
        strobe <= 1'b1;
        @(posedge mclk_i);
        strobe <= 1'b0;
    endtask

    task automatic test_reset_values();
        rd("serial_top", 8'h1F, 8'hA5);
        rd("page_select", 8'h20, 8'h00);
        rd("txn", 8'h21, 8'h00);
        rd("len_low", 8'h22, 8'h00);
        rd("len_high", 8'h23, 8'h00);
    endtask

    // Every page code in turn; each switch is a transaction and captures the length.
    task automatic test_page_codes();
        foreach (codes[i]) begin
            plen <= {8'h01, codes[i]};
            wr(8'hF0, codes[i]);
            rd("page_select", 8'h20, codes[i]);
            rd("txn", 8'h21, 8'(i + 1));
            rd("len_low", 8'h22, codes[i]);
            rd("len_high", 8'h23, 8'h01);
        end
    endtask

    task automatic test_refused();
        wr(8'h20, 8'h16);
        wr(8'h21, 8'hFF);
        wr(8'h22, 8'hFF);
        wr(8'hF0, 8'h55);
        host.sel_mask = 4'h0;
        wr(8'hF0, 8'h16);
        host.sel_mask = 4'h1;
        rd("page_select", 8'h20, 8'h81);
        rd("txn", 8'h21, 8'h06);
        rd("len_low", 8'h22, 8'h81);
        rd("unmapped", 8'h00, 8'h00);
    endtask

    // Zones 0..3 report one, two, none found and invalid: three count as valid.
    task automatic test_results();
        wr(8'hF0, 8'h10);
        temp <= 8'hFB;
        zones <= 128'h39;
        pulse_result();
        rd("seq", 8'h24, 8'h01);
        rd("temp", 8'h25, 8'hFB);
        rd("zones", 8'h26, 8'h03);
        rd("txn", 8'h21, 8'h08);
        ext <= 1'b1;
        sub <= 2'h2;
        pulse_result();
        rd("seq_ext", 8'h24, 8'h06);
        wr(8'h24, 8'hAA);
        rd("seq_after_wr", 8'h24, 8'h06);
    endtask

    // With another application running, the paged bytes come from page memory.
    task automatic test_other_app();
        @(posedge mclk_i);
        page_wr <= 1'b1;
        waddr <= 8'h00;
        wdata <= 8'h5A;
        @(posedge mclk_i);
        page_wr <= 1'b0;
        app <= 8'h02;
        rd("paged_mem", 8'h24, 8'h5A);
    endtask

    // Main sequence.
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        test_reset_values();
        test_page_codes();
        test_refused();
        test_results();
        test_other_app();
        print_verdict();
    end
endmodule
